/* hdl/memory_map_decoder.sv */
// on-chip memory map decoder with AHB-Lite mapping registers
//
// The AHB-Lite slave port is this design's own decision.
module memory_map_decoder
  import memory_map_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b0,
  parameter bit NV_EN_DEFAULT = 1'b1
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // mode pins, asynchronous
  input wire logic mode_pin_first,
  input wire logic mode_pin_second,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // cpu access request
  input wire logic cpu_valid,
  input wire logic [15:0] cpu_addr,
  // registered select toward memories and external bus
  output select_t sel_reg,
  output logic [15:0] sel_addr_reg
);

  // register index of a byte address, or 0 when not word aligned or above the first 1 KB
  function automatic logic [7:0] word_index(input logic [31:0] a);
    word_index = (a[1:0] == 2'b00 && a[31:10] == 22'h0) ? a[9:2] : 8'h00;
  endfunction : word_index

  // pin synchroniser; no reset so the chain fills during reset
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;
  always_ff @(posedge hclk)
  begin
    pin_meta_reg <= {mode_pin_second, mode_pin_first};
    pin_sync_reg <= pin_meta_reg;
  end

  // start-up state and mapping registers
  start_t state_reg, state_next;
  logic [1:0] settle_reg, settle_next;
  logic loader_reg, loader_next;
  logic special_reg, special_next;
  logic expand_reg, expand_next;
  logic [7:0] place_reg, place_next;
  logic [3:0] eeplace_reg, eeplace_next;
  logic [2:0] cfg_reg, cfg_next;
  logic place_wr_reg, place_wr_next;
  logic eeplace_wr_reg, eeplace_wr_next;
  logic cfg_wr_reg, cfg_wr_next;
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_idx_reg, wr_idx_next;
  logic [31:0] rdata_next;
  logic capture;
  logic addr_phase;

  assign addr_phase = hsel && htrans[1] && hready;
  assign capture = (state_reg == ST_SETTLE) && (settle_reg == SETTLE_CYCLES);

  // next values: start-up, mode capture and register writes
  always_comb
  begin
    state_next = state_reg;
    settle_next = settle_reg;
    loader_next = loader_reg;
    special_next = special_reg;
    expand_next = expand_reg;
    place_next = place_reg;
    eeplace_next = eeplace_reg;
    cfg_next = cfg_reg;
    place_wr_next = place_wr_reg;
    eeplace_wr_next = eeplace_wr_reg;
    cfg_wr_next = cfg_wr_reg;
    wr_pend_next = addr_phase && hwrite;
    wr_idx_next = addr_phase ? word_index(haddr) : wr_idx_reg;
    case (state_reg)
      ST_RESET:
      begin
        state_next = ST_SETTLE;
        settle_next = 2'h0;
      end
      ST_SETTLE:
      begin
        settle_next = settle_reg + 2'h1;
        if (capture)
        begin
          // mode latched once at reset release, pins ignored afterwards
          state_next = ST_RUN;
          special_next = !pin_sync_reg[1];
          expand_next = pin_sync_reg[0];
          loader_next = !pin_sync_reg[1] && !pin_sync_reg[0];
          // test mode drops the program ROM; other modes bring it up high
          cfg_next[CFG_ROM_EN] = !(!pin_sync_reg[1] && pin_sync_reg[0]);
          cfg_next[CFG_ROM_PLACE] = 1'b1;
          cfg_next[CFG_NV_EN] = NV_EN_DEFAULT;
        end
      end
      ST_RUN:
      begin
        if (wr_pend_reg)
        begin
          case (wr_idx_reg)
            IDX_MODE:
            begin
              // special flag clears only; mode bits move only in special modes
              if (special_reg)
              begin
                special_next = hwdata[MODE_SPECIAL];
                expand_next = hwdata[MODE_EXPAND];
                loader_next = hwdata[MODE_LOADER] && hwdata[MODE_SPECIAL];
              end
            end
            IDX_PLACE:
            begin
              if (special_reg || !place_wr_reg)
              begin
                place_next = hwdata[7:0];
                place_wr_next = 1'b1;
              end
            end
            IDX_EEPLACE:
            begin
              if (special_reg || !eeplace_wr_reg)
              begin
                eeplace_next = hwdata[3:0];
                eeplace_wr_next = 1'b1;
              end
            end
            IDX_CONFIG:
            begin
              if (special_reg || !cfg_wr_reg)
              begin
                cfg_next = hwdata[2:0];
                cfg_wr_next = 1'b1;
              end
            end
            default:
            begin
              cfg_next = cfg_reg;
            end
          endcase
        end
      end
      default:
      begin
        state_next = ST_RESET;
      end
    endcase
  end

  // read data from next values so a read right after a write sees it
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (addr_phase && !hwrite)
    begin
      case (word_index(haddr))
        IDX_MODE: rdata_next = {24'h0, loader_next, special_next, expand_next, 5'h00};
        IDX_PLACE: rdata_next = {24'h0, place_next};
        IDX_EEPLACE: rdata_next = {28'h0, eeplace_next};
        IDX_CONFIG: rdata_next = {29'h0, cfg_next};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // state registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= ST_RESET;
      settle_reg <= 2'h0;
      loader_reg <= 1'b0;
      special_reg <= 1'b0;
      expand_reg <= 1'b0;
      place_reg <= PLACE_RESET;
      eeplace_reg <= EEPLACE_RESET;
      cfg_reg <= 3'h0;
      place_wr_reg <= 1'b0;
      eeplace_wr_reg <= 1'b0;
      cfg_wr_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      settle_reg <= settle_next;
      loader_reg <= loader_next;
      special_reg <= special_next;
      expand_reg <= expand_next;
      place_reg <= place_next;
      eeplace_reg <= eeplace_next;
      cfg_reg <= cfg_next;
      place_wr_reg <= place_wr_next;
      eeplace_wr_reg <= eeplace_wr_next;
      cfg_wr_reg <= cfg_wr_next;
      wr_pend_reg <= wr_pend_next;
      wr_idx_reg <= wr_idx_next;
      hrdata <= rdata_next;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // address decode; mode keeps the small part's ROM high unless expanded, and gates the bootloader and the fall-through
  logic [3:0] page;
  logic [11:0] low;
  logic hit_reg, hit_ram, hit_boot, hit_ee, hit_rom;
  logic rom_high;
  logic [11:0] ram_top;
  select_t sel_next;
  assign page = cpu_addr[15:12];
  assign low = cpu_addr[11:0];

  always_comb
  begin
    sel_next = '0;
    hit_reg = (page == place_reg[3:0]) && (low <= REG_TOP);
    // shared page leaves the first 128 bytes to the registers
    if (place_reg[7:4] == place_reg[3:0])
    begin
      ram_top = LARGE_VARIANT ? RAM_SHARED_TOP_BIG : RAM_SHARED_TOP;
      hit_ram = (page == place_reg[7:4]) && (low >= RAM_SHARED_BASE) && (low <= ram_top);
    end
    else
    begin
      ram_top = LARGE_VARIANT ? RAM_OWN_TOP_BIG : RAM_OWN_TOP;
      hit_ram = (page == place_reg[7:4]) && (low <= ram_top);
    end
    hit_boot = special_reg && loader_reg && (cpu_addr >= BOOT_BASE)
      && (cpu_addr <= BOOT_TOP);
    // no page is excluded, vectors included
    hit_ee = cfg_reg[CFG_NV_EN] && (page == eeplace_reg) && (low >= EE_BASE);
    // small part moves low only when expanded
    rom_high = cfg_reg[CFG_ROM_PLACE] || (!LARGE_VARIANT && !expand_reg);
    if (rom_high)
    begin
      hit_rom = cpu_addr >= (LARGE_VARIANT ? ROM_HIGH_BASE_BIG : ROM_HIGH_BASE);
    end
    else
    begin
      hit_rom = (cpu_addr <= ROM_LOW_TOP)
        && (LARGE_VARIANT || cpu_addr >= ROM_LOW_BASE);
    end
    hit_rom = hit_rom && cfg_reg[CFG_ROM_EN];
    if (cpu_valid && state_reg == ST_RUN)
    begin
      if (hit_reg)
        sel_next.regs = 1'b1;
      else if (hit_ram)
        sel_next.ram = 1'b1;
      else if (hit_boot)
        sel_next.boot = 1'b1;
      else if (hit_ee)
        sel_next.eeprom = 1'b1;
      else if (hit_rom)
        sel_next.rom = 1'b1;
      else
        sel_next.ext = expand_reg;
    end
  end

  // select registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sel_reg <= '0;
      sel_addr_reg <= 16'h0000;
    end
    else
    begin
      sel_reg <= sel_next;
      sel_addr_reg <= cpu_addr;
    end
  end

  // checks; every property on hclk, quiet while reset is low
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // one select at most, and only once the mode is latched
  chk_one_select: assert property ($onehot0(sel_reg))
    else $error("more than one resource selected");
  chk_idle_before_run: assert property (state_reg != ST_RUN |=> sel_reg == '0)
    else $error("resource selected before mode capture");
  // off-chip only where expanded, and then for every unclaimed address
  chk_ext_single: assert property (sel_reg.ext |-> $past(expand_reg))
    else $error("external access in single-chip mode");
  chk_ext_unclaimed: assert property (cpu_valid && state_reg == ST_RUN && expand_reg
    && !(hit_reg || hit_ram || hit_boot || hit_ee || hit_rom) |=> sel_reg.ext)
    else $error("unclaimed access not passed off-chip");
  // enables gate the optional resources
  chk_rom_enable: assert property (sel_reg.rom |-> $past(cfg_reg[CFG_ROM_EN]))
    else $error("program ROM selected while disabled");
  chk_boot_special: assert property (sel_reg.boot |-> $past(special_reg && loader_reg))
    else $error("bootloader selected outside special mode");

  // register block and ram windows within their pages
  chk_reg_window: assert property (cpu_valid && state_reg == ST_RUN
    && page == place_reg[3:0] && low <= REG_TOP |=> sel_reg.regs)
    else $error("register block not selected in its window");
  chk_ram_shared: assert property (cpu_valid && state_reg == ST_RUN
    && place_reg[7:4] == place_reg[3:0] && page == place_reg[7:4] && low >= RAM_SHARED_BASE
    && low <= (LARGE_VARIANT ? RAM_SHARED_TOP_BIG : RAM_SHARED_TOP) |=> sel_reg.ram)
    else $error("RAM not selected after the register block");
  chk_ram_own_page: assert property (cpu_valid && state_reg == ST_RUN
    && place_reg[7:4] != place_reg[3:0] && page == place_reg[7:4]
    && low <= (LARGE_VARIANT ? RAM_OWN_TOP_BIG : RAM_OWN_TOP) |=> sel_reg.ram)
    else $error("RAM not selected in its own page");

  // eeprom window; it outranks the program ROM, so the vector page works
  chk_ee_window: assert property (sel_reg.eeprom |-> $past(cpu_addr[11:0]) >= EE_BASE
    && $past(cpu_addr[15:12]) == $past(eeplace_reg) && $past(cfg_reg[CFG_NV_EN]))
    else $error("EEPROM selected outside its window");
  chk_ee_vectors: assert property (cpu_valid && state_reg == ST_RUN && cfg_reg[CFG_NV_EN]
    && eeplace_reg == 4'hF && page == 4'hF && low >= EE_BASE && !hit_reg && !hit_ram |=> sel_reg.eeprom)
    else $error("EEPROM not selected over the vector page");
  // bootloader and program ROM ranges
  chk_boot_window: assert property (sel_reg.boot |-> $past(cpu_addr) >= BOOT_BASE
    && $past(cpu_addr) <= BOOT_TOP)
    else $error("bootloader selected outside its window");
  chk_rom_stays_high: assert property (sel_reg.rom && !LARGE_VARIANT
    && !$past(expand_reg) |-> $past(cpu_addr) >= ROM_HIGH_BASE)
    else $error("program ROM moved low outside expanded mode");
  chk_rom_large_low: assert property (sel_reg.rom && LARGE_VARIANT
    && !$past(cfg_reg[CFG_ROM_PLACE]) |-> $past(cpu_addr) <= ROM_LOW_TOP)
    else $error("large program ROM outside its low range");

  // write-once registers: a locked write must leave the value alone
  chk_place_once: assert property (wr_pend_reg && wr_idx_reg == IDX_PLACE
    && !special_reg && place_wr_reg |=> $stable(place_reg))
    else $error("placement register rewritten in normal mode");
  chk_cfg_once: assert property (wr_pend_reg && wr_idx_reg == IDX_CONFIG
    && !special_reg && cfg_wr_reg |=> $stable(cfg_reg))
    else $error("configuration register rewritten in normal mode");
  chk_ee_once: assert property (wr_pend_reg && wr_idx_reg == IDX_EEPLACE
    && !special_reg && eeplace_wr_reg |=> $stable(eeplace_reg))
    else $error("EEPROM placement rewritten in normal mode");

  // latched mode: normal modes cannot move it, nor raise the loader
  chk_mode_frozen: assert property (state_reg == ST_RUN && !special_reg
    |=> !special_reg && $stable(expand_reg))
    else $error("mode changed in a normal mode");
  chk_loader_normal: assert property (!special_reg |-> !loader_reg)
    else $error("bootloader enable set in normal mode");

  // reset and capture values
  chk_place_reset: assert property (state_reg == ST_SETTLE |-> place_reg == PLACE_RESET
    && eeplace_reg == EEPLACE_RESET)
    else $error("placement not at its reset value before run");
  chk_test_rom_off: assert property (capture && !pin_sync_reg[1] && pin_sync_reg[0]
    |=> !cfg_reg[CFG_ROM_EN] && special_reg && expand_reg)
    else $error("test mode reset left program ROM enabled");
  chk_single_rom_on: assert property (capture && pin_sync_reg == 2'b10
    |=> cfg_reg[CFG_ROM_EN] && cfg_reg[CFG_ROM_PLACE] && !expand_reg)
    else $error("single-chip reset did not set ROM bits");
  chk_boot_capture: assert property (capture && pin_sync_reg == 2'b00
    |=> loader_reg && special_reg && !expand_reg)
    else $error("bootstrap reset did not latch the loader enable");
  chk_expand_capture: assert property (capture && pin_sync_reg == 2'b11
    |=> !special_reg && expand_reg && !loader_reg)
    else $error("expanded reset latched the wrong mode");

endmodule : memory_map_decoder

/* hdl/memory_map_pkg.sv */
// constants, field layouts and types for the on-chip memory map decoder
package memory_map_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_MODE = 8'h3C;
  localparam logic [7:0] IDX_PLACE = 8'h3D;
  localparam logic [7:0] IDX_EEPLACE = 8'h3E;
  localparam logic [7:0] IDX_CONFIG = 8'h3F;

  // mode register bit positions
  localparam int MODE_LOADER = 7;
  localparam int MODE_SPECIAL = 6;
  localparam int MODE_EXPAND = 5;

  // configuration register bit positions
  localparam int CFG_ROM_EN = 0;
  localparam int CFG_ROM_PLACE = 1;
  localparam int CFG_NV_EN = 2;

  // reset values
  localparam logic [7:0] PLACE_RESET = 8'h00;
  localparam logic [3:0] EEPLACE_RESET = 4'h0;

  // map limits within a 4K page and absolute ranges
  localparam logic [11:0] REG_TOP = 12'h07F;
  localparam logic [11:0] RAM_SHARED_BASE = 12'h080;
  localparam logic [11:0] RAM_SHARED_TOP = 12'h37F;
  localparam logic [11:0] RAM_SHARED_TOP_BIG = 12'h47F;
  localparam logic [11:0] RAM_OWN_TOP = 12'h2FF;
  localparam logic [11:0] RAM_OWN_TOP_BIG = 12'h3FF;
  localparam logic [11:0] EE_BASE = 12'hD80;
  localparam logic [15:0] BOOT_BASE = 16'hBE00;
  localparam logic [15:0] BOOT_TOP = 16'hBFFF;
  localparam logic [15:0] ROM_HIGH_BASE = 16'hA000;
  localparam logic [15:0] ROM_HIGH_BASE_BIG = 16'h8000;
  localparam logic [15:0] ROM_LOW_BASE = 16'h2000;
  localparam logic [15:0] ROM_LOW_TOP = 16'h7FFF;

  // cycles between reset release and mode capture (pin synchroniser depth)
  localparam logic [1:0] SETTLE_CYCLES = 2'h2;

  // at most one select per access, registered toward the memories
  typedef struct packed {
    logic regs;
    logic ram;
    logic boot;
    logic eeprom;
    logic rom;
    logic ext;
  } select_t;

  // start-up sequence
  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_SETTLE = 3'b010,
    ST_RUN = 3'b100
  } start_t;

endpackage : memory_map_pkg

/* testbench/cpu_access_model.sv */
// cpu core model issuing one-cycle accesses to the decoder
module cpu_access_model
(
  // clock
  input wire logic hclk,
  // access toward the decoder
  output logic cpu_valid,
  output logic [15:0] cpu_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle values at time zero
  initial
  begin
    cpu_valid = 1'b0;
    cpu_addr = 16'h0000;
  end
  // idle address is the inverse of the last one, so stale values never match
  task automatic access(input logic [15:0] addr);
    @(posedge hclk);
    cpu_valid <= 1'b1;
    cpu_addr <= addr;
    @(posedge hclk);
    cpu_valid <= 1'b0;
    cpu_addr <= ~addr;
  endtask : access
endmodule : cpu_access_model

/* testbench/onchip_memory_map_decoder_bench.sv */
// self-checking bench for the memory map decoder
module onchip_memory_map_decoder_bench
  import memory_map_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam select_t NONE = 6'h00;
  localparam select_t REGS = 6'h20;
  localparam select_t RAM = 6'h10;
  localparam select_t BOOT = 6'h08;
  localparam select_t EE = 6'h04;
  localparam select_t ROM = 6'h02;
  localparam select_t EXT = 6'h01;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic mode_pin_first = 1'b0;
  logic mode_pin_second = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic cpu_valid;
  logic [15:0] cpu_addr;
  select_t sel_reg;
  logic [15:0] sel_addr_reg;
  select_t sel_big;
  logic [15:0] addr_big;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  memory_map_decoder i_dut (.hclk(hclk), .hresetn(hresetn),
    .mode_pin_first(mode_pin_first), .mode_pin_second(mode_pin_second),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .cpu_valid(cpu_valid), .cpu_addr(cpu_addr), .sel_reg(sel_reg),
    .sel_addr_reg(sel_addr_reg));
  // larger variant on the same bus and cpu, for its own ranges
  memory_map_decoder #(.LARGE_VARIANT(1'b1)) i_dut_big (.hclk(hclk), .hresetn(hresetn),
    .mode_pin_first(mode_pin_first), .mode_pin_second(mode_pin_second),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(), .hreadyout(), .hresp(),
    .cpu_valid(cpu_valid), .cpu_addr(cpu_addr), .sel_reg(sel_big), .sel_addr_reg(addr_big));
  cpu_access_model i_cpu (.hclk(hclk), .cpu_valid(cpu_valid), .cpu_addr(cpu_addr));
  // 100 MHz clock
  always #5 hclk = ~hclk;
  // hang guard; a normal run needs well under a thousand cycles
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic check_sel(input select_t got, input logic [15:0] got_a, input select_t exp,
                           input logic [15:0] a);
    compares++;
    if (got !== exp || got_a !== a)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t select %h at %h want %h", $time, got, a, exp);
    end
  endtask : check_sel
  task automatic check_resp(input logic got);
    compares++;
    if (got !== 1'b0)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t response %b want OKAY", $time, got);
    end
  endtask : check_resp
  task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t read %h want %h", $time, got, exp);
    end
  endtask : check_data
  // hold pins from reset until capture; writes wait until the decoder runs
  task automatic do_reset(input logic first, input logic second);
    @(posedge hclk);
    hresetn <= 1'b0;
    mode_pin_first <= first;
    mode_pin_second <= second;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
  endtask : do_reset
  // one single word transfer; address phase held until hready is seen
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check_resp(hresp);
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] rd;
    ahb(1'b1, a, {24'h000000, d}, rd);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] rd;
    ahb(1'b0, a, 32'h0, rd);
    check_data(rd, {24'h000000, exp});
  endtask : rd_chk
  // the select lands one edge after the access; look once it has settled
  task automatic probe(input logic [15:0] a, input select_t exp);
    i_cpu.access(a);
    #1;
    check_sel(sel_reg, sel_addr_reg, exp, a);
  endtask : probe
  task automatic probe_big(input logic [15:0] a, input select_t exp);
    i_cpu.access(a);
    #1;
    check_sel(sel_big, addr_big, exp, a);
  endtask : probe_big
  task automatic test_single();
    do_reset(1'b0, 1'b1);
    rd_chk(8'hFC, 8'h07);
    rd_chk(8'hF0, 8'h00);
    probe(16'h0010, REGS);
    probe(16'h0080, RAM);
    probe(16'h037F, RAM);
    probe(16'h0380, NONE);
    probe(16'h0D80, EE);
    probe(16'hA000, ROM);
    probe(16'h8000, NONE);
    probe_big(16'h047F, RAM);
    probe_big(16'h8000, ROM);
    probe(16'hBE00, ROM);
    rd_chk(8'h80, 8'h00);
  endtask : test_single
  // first writes to the mapping registers land, later ones and any mode write in normal mode are dropped
  task automatic test_once();
    wr(8'hF4, 8'h21);
    probe(16'h1000, REGS);
    probe(16'h2000, RAM);
    probe(16'h22FF, RAM);
    probe_big(16'h23FF, RAM);
    probe(16'h2300, NONE);
    wr(8'hF4, 8'h00);
    rd_chk(8'hF4, 8'h21);
    wr(8'hF8, 8'h0F);
    probe(16'hFD80, EE);
    wr(8'hF8, 8'h00);
    probe(16'hFFFF, EE);
    wr(8'hFC, 8'h04);
    probe(16'hA000, NONE);
    wr(8'hFC, 8'h07);
    probe(16'hA000, NONE);
    wr(8'hF0, 8'h80);
    rd_chk(8'hF0, 8'h00);
  endtask : test_once
  // special test: rom starts absent, registers stay writable
  task automatic test_special();
    do_reset(1'b1, 1'b0);
    rd_chk(8'hFC, 8'h06);
    probe(16'hA000, EXT);
    probe(16'h0080, RAM);
    wr(8'hFC, 8'h05);
    probe(16'h2000, ROM);
    probe(16'h1FFF, EXT);
    probe_big(16'h1500, ROM);
    wr(8'hFC, 8'h07);
    probe(16'hA000, ROM);
    wr(8'hFC, 8'h03);
    probe(16'h0D80, EXT);
    wr(8'hF4, 8'h33);
    probe(16'h3080, RAM);
    wr(8'hF4, 8'h44);
    probe(16'h4000, REGS);
  endtask : test_special
  task automatic test_boot_expand();
    do_reset(1'b0, 1'b0);
    rd_chk(8'hF0, 8'hC0);
    probe(16'hBE00, BOOT);
    probe(16'h1000, NONE);
    do_reset(1'b1, 1'b1);
    probe(16'h1000, EXT);
    probe(16'h0010, REGS);
  endtask : test_boot_expand
  // main sequence
  initial
  begin
    test_single();
    test_once();
    test_special();
    test_boot_expand();
    give_verdict();
  end
endmodule : onchip_memory_map_decoder_bench
